// *** design/kms_keybuf.v ***
`default_nettype none

// Key code buffer: a small FIFO that keeps codes until the host pops them.
module kms_keybuf #(
   parameter DEPTH = 16,
   parameter AW = 4,
   parameter W = 8
) (
   input wire clk_sys,
   input wire rst_b,
   input wire push,
   input wire [W-1:0] push_data,
   input wire pop,
   output wire [W-1:0] head_data,
   output wire not_empty,
   output wire [AW:0] count,
   output wire overflow
);

   // Storage for the buffered key codes.
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] cnt_r;
   wire full;
   wire do_pop;
   wire do_push;

   assign full = (cnt_r == DEPTH[AW:0]);
   assign not_empty = (cnt_r != {(AW+1){1'b0}});
   // A pop on an empty buffer is ignored.
   assign do_pop = pop && not_empty;
   // A full buffer refuses new codes unless a pop frees a slot.
   assign do_push = push && (!full || do_pop);
   assign overflow = push && full && !do_pop;
   assign head_data = mem[rd_ptr_r];
   assign count = cnt_r;

   // Stored words are written only; they need no reset.
   always @(posedge clk_sys) begin
      if (do_push) begin
         mem[wr_ptr_r] <= push_data;
      end
   end

   // Pointers and fill count.
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (do_push) begin
            wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (do_push && !do_pop) begin
            cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
         end else if (do_pop && !do_push) begin
            cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule

`default_nettype wire

// *** design/kms_scanner.v ***
// Summary of operation
// - Scan up to 160 keys, 1-20 columns.
// - Row count programmable from one to eight.
// - Key codes kept in sixteen-byte buffer.
// - Scan steps paced at 128 kHz.
// - Scan clock stopped when no key pressed.
// - Three states, idle after reset.
// - Idle drives every column high.
// - Row activity in idle starts scan, requests clock unless other user has it on.
// - Idle clears row-hit and key index.
// - Row counter wraps, then column advances.
// - Both counters terminal: go to scan-end.
// - Key index counts every scanned position.
// - Two or more hits: OR rows into accumulator.
// - Hit in already-hit row sets ghost flag.
// - Scan-end rescans on activity, else idles.
// - N-key rollover, ghost keys locked out.
// - Codes kept until read; overflow drops new codes.
// - Hardware debounce filters glitches.
`include "kms_regs.vh"
`default_nettype none

module kms_scanner #(
   parameter NCOLS = `KMS_MAX_COLS,
   parameter NROWS = `KMS_MAX_ROWS,
   parameter DEPTH = `KMS_BUF_DEPTH
) (
   input wire clk_sys,
   input wire rst_b,
   input wire [NROWS-1:0] row_in,
   output reg [NCOLS-1:0] col_out_r,
   input wire [4:0] cfg_cols,
   input wire [3:0] cfg_rows,
   input wire [2:0] cfg_db_passes,
   input wire other_clk_en,
   output reg clk_req_r,
   output reg [1:0] scan_state_r,
   output reg [7:0] key_index_r,
   output reg ghost_r,
   input wire ghost_clr,
   output reg ovf_r,
   input wire ovf_clr,
   input wire kb_pop,
   output reg [7:0] kb_data_r,
   output reg kb_valid_r,
   output reg [4:0] kb_count_r
);

   // Controller states.
   localparam ST_IDLE = 2'b00;
   localparam ST_SCAN = 2'b01;
   localparam ST_END = 2'b10;
   // Scan divider terminal count, cut to the width of its counter.
   localparam [31:0] DIV_FULL = `KMS_SCAN_DIV - 1;
   localparam [7:0] DIV_LAST = DIV_FULL[7:0];

   // Limit a programmed row count to 1..NROWS.
   function [3:0] clamp_rows;
      input [3:0] r;
      begin
         if (r == 4'h0) begin
            clamp_rows = 4'h1;
         end else if (r > NROWS) begin
            clamp_rows = NROWS[3:0];
         end else begin
            clamp_rows = r;
         end
      end
   endfunction

   // Limit a programmed column count to 1..NCOLS.
   function [4:0] clamp_cols;
      input [4:0] c;
      begin
         if (c == 5'h00) begin
            clamp_cols = 5'h01;
         end else if (c > NCOLS) begin
            clamp_cols = NCOLS[4:0];
         end else begin
            clamp_cols = c;
         end
      end
   endfunction

   // True when at least two bits of a row vector are set.
   function two_plus;
      input [7:0] m;
      begin
         two_plus = ((m & (m - 8'h01)) != 8'h00);
      end
   endfunction

   // Synchronised row inputs; a pressed key reads as one.
   wire [NROWS-1:0] row_s;
   // Row vector padded to eight bits for the accumulator.
   wire [7:0] row8;
   // Rows beyond the programmed count are masked off.
   wire [7:0] row_mask;
   wire [7:0] row_pr;
   wire [3:0] rows_lim;
   wire [4:0] cols_lim;
   wire row_last;
   wire col_last;
   wire hit;
   wire ghost_now;
   wire scan_tick;
   wire clk_on;
   wire [7:0] buf_head;
   wire buf_ne;
   wire [4:0] buf_cnt;
   wire buf_ovf;

   reg [1:0] state_r;
   reg [7:0] div_r;
   reg [2:0] row_cnt_r;
   reg [4:0] col_cnt_r;
   // Rows that showed multiple hits in an earlier column.
   reg [7:0] row_hit_r;
   // Any activity during the current pass.
   reg pass_hit_r;
   // Debounced state and pending-change count of every key.
   reg key_st [0:`KMS_MAX_KEYS-1];
   reg [2:0] db_cnt [0:`KMS_MAX_KEYS-1];
   reg push_r;
   reg [7:0] push_code_r;
   reg [2:0] db_need;
   integer i;

   // Row pins come from outside the clock domain.
   kms_sync #(
      .W(NROWS)
   ) u_row_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .din(row_in),
      .dout(row_s)
   );

   // Key code store that the host drains.
   // sixteen-byte store
   kms_keybuf #(
      .DEPTH(DEPTH),
      .AW(`KMS_BUF_AW),
      .W(`KMS_CODE_W)
   ) u_keybuf (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .push(push_r),
      .push_data(push_code_r),
      .pop(kb_pop),
      .head_data(buf_head),
      .not_empty(buf_ne),
      .count(buf_cnt),
      .overflow(buf_ovf)
   );

   assign cols_lim = clamp_cols(cfg_cols);
   assign rows_lim = clamp_rows(cfg_rows);
   // Pad the row vector only when there are fewer than eight rows.
   generate
      if (NROWS < 8) begin : g_row_pad
         assign row8 = {{(8-NROWS){1'b0}}, row_s};
      end else begin : g_row_full
         assign row8 = row_s[7:0];
      end
   endgenerate
   assign row_mask = 8'hFF >> (4'h8 - rows_lim);
   assign row_pr = row8 & row_mask;
   assign row_last = ({1'b0, row_cnt_r} == rows_lim - 4'h1);
   assign col_last = (col_cnt_r == cols_lim - 5'h01);
   assign hit = row_pr[row_cnt_r];
   assign ghost_now = hit && row_hit_r[row_cnt_r];
   // The scan clock runs for us or for another user.
   assign clk_on = clk_req_r || other_clk_en;
   // one step per 128 kHz period
   assign scan_tick = clk_on && (div_r == DIV_LAST);

   // Debounce pass count, never below one.
   always @* begin
      db_need = cfg_db_passes;
      if (cfg_db_passes == 3'h0) begin
         db_need = 3'h1;
      end
   end

   // Scan clock divider; it is held at zero while no one needs the clock.
   // It also restarts on every entry to scan, so a clock shared with
   // another user cannot step before the first column has settled.
   // divider clears to zero and halts when neither we nor the other user enable the clock
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 8'h00;
      end else if (!clk_on || scan_tick || state_r != ST_SCAN) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   // Main controller: counters, accumulator and clock request.
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         clk_req_r <= 1'b0;
         row_cnt_r <= 3'h0;
         col_cnt_r <= 5'h00;
         row_hit_r <= `KMS_ZERO8;
         key_index_r <= `KMS_ZERO8;
         pass_hit_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               row_hit_r <= `KMS_ZERO8;
               key_index_r <= `KMS_ZERO8;
               row_cnt_r <= 3'h0;
               col_cnt_r <= 5'h00;
               pass_hit_r <= 1'b0;
               if (row_pr != 8'h00) begin
                  clk_req_r <= !other_clk_en;
                  state_r <= ST_SCAN;
               end
            end
            ST_SCAN: begin
               // Keep a request alive if the other user drops out.
               clk_req_r <= clk_req_r || !other_clk_en;
               if (scan_tick) begin
                  key_index_r <= key_index_r + 8'h01;
                  if (hit || key_st[key_index_r] ||
                      db_cnt[key_index_r] != 3'h0) begin
                     pass_hit_r <= 1'b1;
                  end
                  if (row_last) begin
                     row_cnt_r <= 3'h0;
                     if (two_plus(row_pr)) begin
                        row_hit_r <= row_hit_r | row_pr;
                     end
                     if (col_last) begin
                        state_r <= ST_END;
                     end else begin
                        col_cnt_r <= col_cnt_r + 5'h01;
                     end
                  end else begin
                     row_cnt_r <= row_cnt_r + 3'h1;
                  end
               end
            end
            ST_END: begin
               // Every pass starts from the first key.
               row_cnt_r <= 3'h0;
               col_cnt_r <= 5'h00;
               row_hit_r <= `KMS_ZERO8;
               key_index_r <= `KMS_ZERO8;
               pass_hit_r <= 1'b0;
               if (pass_hit_r) begin
                  state_r <= ST_SCAN;
               end else begin
                  state_r <= ST_IDLE;
                  clk_req_r <= 1'b0;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               clk_req_r <= 1'b0;
            end
         endcase
      end
   end

   // Per-key debounce: a change is taken after N equal passes.
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i < `KMS_MAX_KEYS; i = i + 1) begin
            key_st[i] <= 1'b0;
            db_cnt[i] <= 3'h0;
         end
         push_r <= 1'b0;
         push_code_r <= 8'h00;
      end else begin
         push_r <= 1'b0;
         if (state_r == ST_SCAN && scan_tick) begin
            if (hit != key_st[key_index_r]) begin
               if (db_cnt[key_index_r] + 3'h1 >= db_need) begin
                  key_st[key_index_r] <= hit;
                  db_cnt[key_index_r] <= 3'h0;
                  if (hit && !ghost_now) begin
                     push_r <= 1'b1;
                     push_code_r <= key_index_r;
                  end
               end else begin
                  db_cnt[key_index_r] <= db_cnt[key_index_r] + 3'h1;
               end
            end else begin
               // A glitch that went away restarts the count.
               db_cnt[key_index_r] <= 3'h0;
            end
         end
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle.
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ghost_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         if (state_r == ST_SCAN && scan_tick && ghost_now) begin
            ghost_r <= 1'b1;
         end else if (ghost_clr) begin
            ghost_r <= 1'b0;
         end
         if (buf_ovf) begin
            ovf_r <= 1'b1;
         end else if (ovf_clr) begin
            ovf_r <= 1'b0;
         end
      end
   end

   // Column drive and pollable status, all from flip-flops.
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         col_out_r <= {NCOLS{1'b1}};
         scan_state_r <= ST_IDLE;
         kb_data_r <= 8'h00;
         kb_valid_r <= 1'b0;
         kb_count_r <= 5'h00;
      end else begin
         if (state_r == ST_SCAN) begin
            col_out_r <= {{(NCOLS-1){1'b0}}, 1'b1} << col_cnt_r;
         end else begin
            col_out_r <= {NCOLS{1'b1}};
         end
         scan_state_r <= state_r;
         // head code stays until popped; empty shows zero.
         kb_data_r <= buf_ne ? buf_head : 8'h00;
         kb_valid_r <= buf_ne;
         kb_count_r <= buf_cnt;
      end
   end

endmodule

`default_nettype wire

// *** design/kms_sync.v ***
`default_nettype none

// Two-stage synchroniser for pin inputs; only the second stage is read.
module kms_sync #(
   parameter W = 8
) (
   input wire clk_sys,
   input wire rst_b,
   input wire [W-1:0] din,
   output reg [W-1:0] dout
);

   // First stage, read only by the second stage.
   reg [W-1:0] meta_r;

   // Both stages clear to zero, the idle level of pulled-down rows.
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= {W{1'b0}};
         dout <= {W{1'b0}};
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end

endmodule

`default_nettype wire

// *** pkg/kms_regs.vh ***
`ifndef KMS_REGS_VH
`define KMS_REGS_VH

// System clock rate in hertz.
`define KMS_CLK_HZ 20000000
// Scan clock rate in hertz.
`define KMS_SCAN_HZ 128000
// System clock cycles per scan step, rounded down.
`define KMS_SCAN_DIV (`KMS_CLK_HZ / `KMS_SCAN_HZ)
// Largest matrix supported.
`define KMS_MAX_COLS 20
`define KMS_MAX_ROWS 8
`define KMS_MAX_KEYS 160
// Key code buffer depth in bytes and its pointer width.
`define KMS_BUF_DEPTH 16
`define KMS_BUF_AW 4
// Width of a key code.
`define KMS_CODE_W 8
// Reset value of the row-hit accumulator and key-index counter.
`define KMS_ZERO8 8'h00
// Default consecutive-pass count for debounce.
`define KMS_DB_DEFAULT 3'h2

`endif

// *** verif/kms_key_matrix.sv ***
`default_nettype none
// Passive switch matrix: a closed switch joins its column to its row.
module kms_key_matrix #(
   parameter int NCOLS = 20,
   parameter int NROWS = 8
) (
   input wire logic [NCOLS-1:0] col_drive,
   input wire logic [NCOLS*NROWS-1:0] closed,
   output logic [NROWS-1:0] row_sense
);
   timeunit 1ns;
   timeprecision 1ns;
   // Rows rest low on their pull-downs; a driven column lifts a row.
   always_comb begin
      row_sense = {NROWS{1'b0}};
      for (int c = 0; c < NCOLS; c++)
         for (int r = 0; r < NROWS; r++)
            if (col_drive[c] && closed[c*NROWS+r]) row_sense[r] = 1'b1;
   end
endmodule
`default_nettype wire

// *** verif/kms_scanner_props.sv ***
`default_nettype none
// Checker on the scanner's ports: state, column drive, index and flags.
module kms_scanner_props #(
   parameter int NCOLS = 20,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic other_clk_en,
   input wire logic [NCOLS-1:0] col_out_r,
   input wire logic clk_req_r,
   input wire logic [1:0] scan_state_r,
   input wire logic [7:0] key_index_r,
   input wire logic ghost_r,
   input wire logic ghost_clr,
   input wire logic ovf_r,
   input wire logic ovf_clr,
   input wire logic kb_valid_r,
   input wire logic [4:0] kb_count_r
);
   timeunit 1ns;
   timeprecision 1ns;
   // All checks run on the system clock and sleep through reset.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_state_code: assert property (scan_state_r != 2'h3)
      else $error("scanner state code is not defined");
   a_idle_cols: assert property ((scan_state_r == 2'h0 &&
      $past(scan_state_r) == 2'h0) |-> &col_out_r)
      else $error("column drive not all high in idle");
   a_scan_onehot: assert property ((scan_state_r == 2'h1 &&
      $past(scan_state_r) == 2'h1 && $past(scan_state_r, 2) == 2'h1)
      |-> $onehot(col_out_r))
      else $error("column drive not one-hot during scan");
   a_req_start: assert property ((scan_state_r == 2'h1 &&
      $past(scan_state_r) == 2'h0 && !$past(other_clk_en)) |-> clk_req_r)
      else $error("scan started without a clock request");
   // The request moves with the internal state, one cycle ahead of scan_state_r.
   a_idle_no_req: assert property (scan_state_r == 2'h0
      |-> !$past(clk_req_r))
      else $error("clock request held while idle");
   a_idle_index: assert property ((scan_state_r == 2'h0 &&
      $past(scan_state_r) == 2'h0) |-> key_index_r == 8'h00)
      else $error("key index not cleared in idle");
   a_end_short: assert property (scan_state_r == 2'h2
      |=> scan_state_r != 2'h2)
      else $error("scan-end held for more than one cycle");
   a_index_step: assert property ((key_index_r != $past(key_index_r))
      |-> (key_index_r == $past(key_index_r) + 8'h01 || key_index_r == 8'h00))
      else $error("key index moved by other than one");
   a_index_pace: assert property ((key_index_r != $past(key_index_r) &&
      key_index_r != 8'h00) |=> ($stable(key_index_r) ||
      key_index_r == 8'h00) [*8])
      else $error("scan steps come too close together");
   a_valid_count: assert property (kb_valid_r ==
      (kb_count_r != 5'h00) && kb_count_r <= DEPTH)
      else $error("buffer valid flag or fill count wrong");
   a_ovf_sticky: assert property (($past(ovf_r) && !$past(ovf_clr))
      |-> ovf_r)
      else $error("overflow flag dropped without a clear");
   a_ovf_full: assert property ($rose(ovf_r)
      |-> kb_count_r == DEPTH)
      else $error("overflow raised while buffer not full");
   a_ghost_sticky: assert property (($past(ghost_r) &&
      !$past(ghost_clr)) |-> ghost_r)
      else $error("ghost flag dropped without a clear");
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`default_nettype none
// Bench: a switch matrix model feeds the rows, tasks poll the buffer.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0; // System clock.
   logic rst_b = 1'b0; // Reset, active low.
   logic [159:0] keys = 160'h0; // Closed switches, index col*8+row.
   logic [4:0] cfg_cols = 5'h03; // Columns scanned.
   logic [3:0] cfg_rows = 4'h2; // Rows scanned.
   logic [2:0] cfg_db_passes = 3'h1; // Debounce passes.
   logic other_clk_en = 1'b0; // No other user of the scan clock.
   logic ghost_clr = 1'b0;
   logic ovf_clr = 1'b0;
   logic kb_pop = 1'b0;
   logic [7:0] row_in;
   logic [19:0] col_out_r;
   logic clk_req_r, ghost_r, ovf_r, kb_valid_r;
   logic [1:0] scan_state_r;
   logic [7:0] key_index_r, kb_data_r;
   logic [4:0] kb_count_r;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   kms_key_matrix u_keys (.col_drive(col_out_r), .closed(keys),
      .row_sense(row_in));
   kms_scanner u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .row_in(row_in),
      .col_out_r(col_out_r), .cfg_cols(cfg_cols), .cfg_rows(cfg_rows),
      .cfg_db_passes(cfg_db_passes), .other_clk_en(other_clk_en),
      .clk_req_r(clk_req_r), .scan_state_r(scan_state_r),
      .key_index_r(key_index_r), .ghost_r(ghost_r), .ghost_clr(ghost_clr),
      .ovf_r(ovf_r), .ovf_clr(ovf_clr), .kb_pop(kb_pop),
      .kb_data_r(kb_data_r), .kb_valid_r(kb_valid_r),
      .kb_count_r(kb_count_r));
   // A 50 ns period gives the 20 MHz system clock.
   always #25 clk_sys = ~clk_sys;
   // Compares one result and reports a mismatch at once.
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   // Waits for a scanner state, bounded so a hang cannot stall here.
   task automatic wait_state(input logic [1:0] s);
      for (int n = 0; n < 20000 && scan_state_r !== s; n++)
         @(negedge clk_sys);
   endtask
   // Polls the buffer fill count, bounded as above.
   task automatic wait_count(input logic [4:0] c);
      for (int n = 0; n < 20000 && kb_count_r !== c; n++)
         @(negedge clk_sys);
   endtask
   // Pops the head code; status settles before the next request.
   task automatic pop();
      kb_pop = 1'b1;
      @(negedge clk_sys);
      kb_pop = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask
   // Prints the counts and the verdict, then stops the run.
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run length.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         close_out();
      end
   end
   // Main sequence of scenarios.
   initial begin
      repeat (8) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      chk(20'(scan_state_r), 20'h0);
      chk(col_out_r, 20'hFFFFF);
      chk(20'(key_index_r), 20'h0);
      keys[5] = 1'b1;
      repeat (20) @(negedge clk_sys);
      chk(20'(scan_state_r), 20'h0);
      keys = 160'h0;
      keys[17] = 1'b1;
      wait_state(2'h1);
      chk(20'(clk_req_r), 20'h1);
      wait_count(5'h01);
      chk(20'(kb_data_r), 20'h05);
      pop();
      chk(20'(kb_valid_r), 20'h0);
      keys = 160'h0;
      wait_state(2'h0);
      chk(20'(clk_req_r), 20'h0);
      keys[0] = 1'b1;
      keys[1] = 1'b1;
      keys[8] = 1'b1;
      wait_count(5'h02);
      wait_state(2'h2);
      repeat (4) @(negedge clk_sys);
      chk(20'(ghost_r), 20'h1);
      chk(20'(kb_count_r), 20'h2);
      chk(20'(kb_data_r), 20'h00);
      pop();
      chk(20'(kb_data_r), 20'h01);
      pop();
      keys = 160'h0;
      wait_state(2'h0);
      ghost_clr = 1'b1;
      @(negedge clk_sys);
      ghost_clr = 1'b0;
      @(negedge clk_sys);
      chk(20'(ghost_r), 20'h0);
      // A press seen in one pass only is a glitch and is never reported.
      cfg_db_passes = 3'h2;
      other_clk_en = 1'b1;
      keys[16] = 1'b1;
      wait_state(2'h1);
      chk(20'(clk_req_r), 20'h0);
      wait_state(2'h2);
      keys = 160'h0;
      wait_state(2'h0);
      chk(20'(kb_count_r), 20'h0);
      other_clk_en = 1'b0;
      // A steady press is reported after the second equal pass.
      keys[16] = 1'b1;
      wait_state(2'h1);
      wait_state(2'h2);
      chk(20'(kb_count_r), 20'h0);
      wait_state(2'h1);
      wait_state(2'h2);
      chk(20'(kb_count_r), 20'h1);
      chk(20'(kb_data_r), 20'h04);
      pop();
      keys = 160'h0;
      wait_state(2'h0);
      cfg_db_passes = 3'h1;
      cfg_cols = 5'h01;
      cfg_rows = 4'h8;
      for (int i = 0; i < 3; i++) begin
         keys[7:0] = 8'hFF;
         wait_state(2'h1);
         wait_state(2'h2);
         keys = 160'h0;
         wait_state(2'h0);
      end
      chk(20'(kb_count_r), 20'h10);
      chk(20'(ovf_r), 20'h1);
      chk(20'(kb_data_r), 20'h00);
      chk(20'(ghost_r), 20'h0);
      ovf_clr = 1'b1;
      @(negedge clk_sys);
      ovf_clr = 1'b0;
      @(negedge clk_sys);
      chk(20'(ovf_r), 20'h0);
      close_out();
   end
endmodule
bind kms_scanner kms_scanner_props #(.NCOLS(NCOLS), .DEPTH(DEPTH)) u_props (
   .clk_sys(clk_sys), .rst_b(rst_b), .other_clk_en(other_clk_en),
   .col_out_r(col_out_r), .clk_req_r(clk_req_r),
   .scan_state_r(scan_state_r), .key_index_r(key_index_r),
   .ghost_r(ghost_r), .ghost_clr(ghost_clr), .ovf_r(ovf_r),
   .ovf_clr(ovf_clr), .kb_valid_r(kb_valid_r), .kb_count_r(kb_count_r));
`default_nettype wire
